//--- design/tec_timer.sv
// Purpose: two 8-bit count-up timer/event counters behind an AHB-Lite slave
// Assumes: core_clk at 200 MHz, timer pins asynchronous to core_clk
// Notes: overflow sets sticky status bits, gated by a mask onto irq
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tec_timer_defs.svh"

module tec_timer (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire tec_pkg::tec_unit_vec_t timer_pin,
    input wire logic power_down,
    output logic irq,
    output logic wake_req
);
    import tec_pkg::*;

    // byte offset of a unit's count or control register
    function automatic logic [7:0] unit_offset(input int unsigned unit, input logic is_ctrl);
        logic [7:0] base;
        base = is_ctrl ? `TEC_OFF_CTRL0 : `TEC_OFF_COUNT0;
        unit_offset = base + (unit[0] ? `TEC_UNIT_STRIDE : 8'h00);
    endfunction

    // all-ones mask of the prescaler bits that must be full for one tick
    function automatic logic [`TEC_PSC_WIDTH-1:0] psc_mask(input logic [2:0] sel);
        psc_mask = ~({`TEC_PSC_WIDTH{1'b1}} << sel);
    endfunction

    // bus data phase state
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic rd_done;
    logic wr_en;
    logic wr_stat;
    logic wr_mask;

    // pin synchroniser and edge detection
    tec_unit_vec_t pin_meta;
    tec_unit_vec_t pin_sync;
    tec_unit_vec_t pin_prev;
    tec_unit_vec_t pin_rise;
    tec_unit_vec_t pin_fall;

    // per-unit state
    tec_ctrl_t ctrl [2];
    logic [7:0] count [2];
    logic [7:0] preload [2];
    logic [`TEC_PSC_WIDTH-1:0] pre [2];
    tec_pw_state_t pw_state [2];
    tec_unit_vec_t ovf;
    tec_unit_vec_t ovf_event_mode;

    // interrupt registers
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // always OKAY; reads take one wait state so read data comes from a flop
    assign hresp = 1'b0;
    assign hreadyout = ce && !(dp_valid && !dp_write && !rd_done);
    assign wr_en = ce && dp_valid && dp_write;
    assign wr_stat = wr_en && (dp_addr == `TEC_OFF_IRQ_STATUS);
    assign wr_mask = wr_en && (dp_addr == `TEC_OFF_IRQ_MASK);

    // address phase capture
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (ce && hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // read data register, loaded in the wait cycle of a read
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_done <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            rd_done <= dp_valid && !dp_write && !rd_done;
            if (dp_valid && !dp_write && !rd_done) begin
                case (dp_addr)
                    `TEC_OFF_COUNT0: hrdata <= {24'h000000, count[0]};
                    `TEC_OFF_CTRL0: hrdata <= {24'h000000, ctrl[0] & `TEC_CTRL_WMASK};
                    `TEC_OFF_COUNT1: hrdata <= {24'h000000, count[1]};
                    `TEC_OFF_CTRL1: hrdata <= {24'h000000, ctrl[1] & `TEC_CTRL_WMASK};
                    `TEC_OFF_IRQ_STATUS: hrdata <= {30'h0, irq_status};
                    `TEC_OFF_IRQ_MASK: hrdata <= {30'h0, irq_mask};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_meta <= 2'b00;
            pin_sync <= 2'b00;
            pin_prev <= 2'b00;
        end else if (ce) begin
            pin_meta <= timer_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync & ~pin_prev;
    assign pin_fall = ~pin_sync & pin_prev;

    for (genvar u = 0; u < 2; u++) begin : g_unit
        logic wr_count;
        logic wr_ctrl;
        logic tick;
        logic act_edge;
        logic idle_edge;
        logic pulse_on;
        logic pre_run;
        logic inc;
        logic pw_stop;
        logic [7:0] reload;

        assign wr_count = wr_en && (dp_addr == unit_offset(u, 1'b0));
        assign wr_ctrl = wr_en && (dp_addr == unit_offset(u, 1'b1));

        assign tick = (pre[u] & psc_mask(ctrl[u].psc)) == psc_mask(ctrl[u].psc);

        assign act_edge = ctrl[u].edge_sel ? pin_rise[u] : pin_fall[u];
        assign idle_edge = ctrl[u].edge_sel ? pin_fall[u] : pin_rise[u];

        assign pulse_on = ctrl[u].run && (ctrl[u].mode == TEC_MODE_PULSE);
        assign pw_stop = pulse_on && (pw_state[u] == TEC_PW_COUNT) && idle_edge;

        // prescaler runs only for internal clocking
        assign pre_run = (ctrl[u].run && (ctrl[u].mode == TEC_MODE_TIMER))
            || (pulse_on && (pw_state[u] == TEC_PW_COUNT));

        // mode decode of the count enable
        always_comb begin
            case (ctrl[u].mode)
                TEC_MODE_TIMER: inc = ctrl[u].run && tick;
                TEC_MODE_EVENT: inc = ctrl[u].run && (ctrl[u].edge_sel ? pin_fall[u] : pin_rise[u]);
                TEC_MODE_PULSE: inc = pulse_on && (pw_state[u] == TEC_PW_COUNT) && tick && !idle_edge;
                default: inc = 1'b0;
            endcase
        end

        assign ovf[u] = inc && (count[u] == `TEC_COUNT_FULL);
        assign ovf_event_mode[u] = ovf[u] && (ctrl[u].mode == TEC_MODE_EVENT);
        // a preload written in the overflow cycle is the one reloaded
        assign reload = wr_count ? hwdata[7:0] : preload[u];

        // prescaler counter, cleared while idle so each run starts aligned
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                pre[u] <= '0;
            end else if (ce) begin
                if (pre_run) begin
                    pre[u] <= pre[u] + 1'b1;
                end else begin
                    pre[u] <= '0;
                end
            end
        end

        // pulse width measurement sequencer
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                pw_state[u] <= TEC_PW_IDLE;
            end else if (ce) begin
                case (pw_state[u])
                    TEC_PW_IDLE: begin
                        if (pulse_on) begin
                            pw_state[u] <= TEC_PW_ARMED;
                        end
                    end
                    TEC_PW_ARMED: begin
                        if (!pulse_on) begin
                            pw_state[u] <= TEC_PW_IDLE;
                        end else if (act_edge) begin
                            pw_state[u] <= TEC_PW_COUNT;
                        end
                    end
                    TEC_PW_COUNT: begin
                        if (!pulse_on || idle_edge) begin
                            pw_state[u] <= TEC_PW_IDLE;
                        end
                    end
                    default: pw_state[u] <= TEC_PW_IDLE;
                endcase
            end
        end

        // control register; a software write wins over the automatic stop
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                ctrl[u] <= `TEC_CTRL_RESET;
            end else if (ce) begin
                if (wr_ctrl) begin
                    ctrl[u] <= hwdata[7:0] & `TEC_CTRL_WMASK;
                end else if (pw_stop) begin
                    ctrl[u].run <= 1'b0;
                end
            end
        end

        // preload register, always written by software
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                preload[u] <= `TEC_PRELOAD_RESET;
            end else if (ce && wr_count) begin
                preload[u] <= hwdata[7:0];
            end
        end

        // counter register
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                count[u] <= `TEC_COUNT_RESET;
            end else if (ce) begin
                if (wr_count && !ctrl[u].run) begin
                    count[u] <= hwdata[7:0];
                end else if (ovf[u]) begin
                    count[u] <= reload;
                end else if (inc) begin
                    count[u] <= count[u] + 8'h01;
                end
            end
        end
    end

    // sticky status, write one to clear; a new overflow wins over the clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_status <= `TEC_IRQ_RESET;
        end else if (ce) begin
            irq_status <= (irq_status & ~(wr_stat ? hwdata[1:0] : 2'b00)) | ovf;
        end
    end

    // interrupt enables
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_mask <= `TEC_IRQ_RESET;
        end else if (ce && wr_mask) begin
            irq_mask <= hwdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wake_req <= 1'b0;
        end else if (ce) begin
            wake_req <= power_down && (|ovf_event_mode);
        end
    end

endmodule
`default_nettype wire

//--- design/tec_timer_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the timer/event counter pair
// Assumes: 32-bit AHB-Lite data, one aligned word per register, low address byte decoded
// Notes: definitions only
`ifndef TEC_TIMER_DEFS_SVH
`define TEC_TIMER_DEFS_SVH

// register byte offsets
`define TEC_OFF_COUNT0 8'h00
`define TEC_OFF_CTRL0 8'h04
`define TEC_OFF_COUNT1 8'h08
`define TEC_OFF_CTRL1 8'h0c
`define TEC_OFF_IRQ_STATUS 8'h10
`define TEC_OFF_IRQ_MASK 8'h14
`define TEC_UNIT_STRIDE 8'h08

// control register field positions
`define TEC_CTRL_MODE_HI 7
`define TEC_CTRL_MODE_LO 6
`define TEC_CTRL_UNUSED_BIT 5
`define TEC_CTRL_RUN_BIT 4
`define TEC_CTRL_EDGE_BIT 3
`define TEC_CTRL_PSC_HI 2
`define TEC_CTRL_PSC_LO 0
`define TEC_CTRL_WMASK 8'hdf

// reset values
`define TEC_CTRL_RESET 8'h00
`define TEC_COUNT_RESET 8'h00
`define TEC_PRELOAD_RESET 8'h00
`define TEC_IRQ_RESET 2'h0
`define TEC_COUNT_FULL 8'hff

// prescaler depth: seven stages give 1:1 up to 1:128
`define TEC_PSC_WIDTH 7

`endif

//--- design/tec_pkg.sv
// Purpose: types shared by the timer/event counter pair
// Assumes: two identical 8-bit units
// Notes: field positions match the defines header
package tec_pkg;

    typedef logic [1:0] tec_unit_vec_t;

    typedef enum logic [1:0] {
        TEC_MODE_NONE = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_t;

    typedef struct packed {
        tec_mode_t mode;
        logic unused;
        logic run;
        logic edge_sel;
        logic [2:0] psc;
    } tec_ctrl_t;

    typedef enum logic [1:0] {
        TEC_PW_IDLE = 2'b00,
        TEC_PW_ARMED = 2'b01,
        TEC_PW_COUNT = 2'b10
    } tec_pw_state_t;

endpackage

//--- tb/tec_timer_sva.sv
// Purpose: bus and interrupt timing checks on the timer pair
// Assumes: one clock domain, reset active high
// Notes: bound onto tec_timer
`timescale 1ns/1ps
`default_nettype none
module tec_timer_sva (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire tec_pkg::tec_unit_vec_t timer_pin,
    input wire logic power_down,
    input wire logic irq,
    input wire logic wake_req
);
    import tec_pkg::*;
    logic rd_go;
    logic wr_go;
    // transfers taken at this edge
    assign rd_go = ce && hready && hsel && htrans[1] && !hwrite;
    assign wr_go = ce && hready && hsel && htrans[1] && hwrite;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_resp_okay: assert property (hresp == 1'b0) // bus OKAY
        else $error("hresp not okay");
    a_write_no_wait: assert property (wr_go ##1 ce |-> hreadyout) // bus timing
        else $error("write data phase stalled");
    a_read_one_wait: assert property (rd_go ##1 ce |-> !hreadyout ##1 (hreadyout || !ce)) // bus timing
        else $error("read wait state wrong");
    a_ready_drop_cause: assert property ($fell(hreadyout) |-> $past(rd_go) || !ce) // bus timing
        else $error("hreadyout dropped without read");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_go, 2)) // bus timing
        else $error("hrdata changed without read");
    a_wake_one_cycle: assert property (wake_req |=> !wake_req)
        else $error("wake request too long");
    a_wake_needs_down: assert property (wake_req |-> $past(power_down))
        else $error("wake request while awake");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_go, 2))
        else $error("irq dropped without write");
endmodule
bind tec_timer tec_timer_sva u_tec_timer_sva (.core_clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .timer_pin, .power_down, .irq, .wake_req);
`default_nettype wire

//--- tb/tec_pin_src.sv
// Purpose: external event and pulse source on the timer pins
// Assumes: called just after a rising edge
// Notes: each level held w clocks, slow or prompt
`timescale 1ns/1ps
`default_nettype none
module tec_pin_src (
    input wire logic core_clk,
    output tec_pkg::tec_unit_vec_t timer_pin
);
    import tec_pkg::*;
    initial timer_pin = 2'h0;
    // flips pin u n times, holding each level w clocks
    task automatic toggle(input int u, input int n, input int w);
        repeat (n) begin
            timer_pin[u] <= ~timer_pin[u];
            repeat (w) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the timer pair
// Assumes: ce held high except for the 30 clocks that t_ce drops it, hready fed from hreadyout
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "tec_timer_defs.svh"
module tb_top;
    import tec_pkg::*;
    localparam logic [7:0] cnt0 = `TEC_OFF_COUNT0, ctl0 = `TEC_OFF_CTRL0, cnt1 = `TEC_OFF_COUNT1;
    localparam logic [7:0] ctl1 = `TEC_OFF_CTRL1, sts = `TEC_OFF_IRQ_STATUS, msk = `TEC_OFF_IRQ_MASK;
    logic core_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, power_down = 1'b0, woke = 1'b0;
    logic ce = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, q2;
    logic hreadyout, hresp, irq, wake_req;
    tec_unit_vec_t timer_pin;
    int fail_count = 0, cmp_count = 0;
    // clock and wake capture
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (wake_req === 1'b1) woke <= 1'b1;
    tec_timer u_tec_timer (.core_clk(core_clk), .reset(reset), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_pin(timer_pin),
        .power_down(power_down), .irq(irq), .wake_req(wake_req));
    tec_pin_src u_tec_pin_src (.core_clk(core_clk), .timer_pin(timer_pin));
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one single AHB transfer, read data left in q
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(negedge core_clk); while (hreadyout !== 1'b1 && ++i < 50);
        @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= d;
        do @(negedge core_clk); while (hreadyout !== 1'b1 && ++i < 50);
        q = hrdata;
        @(posedge core_clk);
        if (i >= 50) begin
            fail_count++;
            close_out;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, q, e);
    endtask
    task automatic irq_is(input logic e, input string n);
        @(negedge core_clk);
        chk(n, irq, e);
        @(posedge core_clk);
    endtask
    // unused bit, mode none, unmapped space
    task automatic t_regs;
        rd(ctl0, 32'h0, "ctrl0 reset");
        wr(ctl0, 32'h3f);
        tick(40);
        rd(ctl0, 32'h1f, "ctrl0 bit5");
        rd(cnt0, 32'h0, "mode none count");
        rd(8'h40, 32'h0, "unmapped read");
    endtask
    // prescale sweep in timer mode
    task automatic t_psc;
        for (int k = 0; k < 8; k++) begin
            wr(ctl0, 32'h80);
            wr(cnt0, 32'h0);
            wr(ctl0, 32'h90 | k);
            tick((20 << k) - 2);
            wr(ctl0, 32'h80);
            xfer(1'b0, cnt0, 32'h0);
            chk("prescale", 32'(q >= 19 && q <= 21), 32'h1);
        end
    endtask
    // reload, preload while running, interrupt gating
    task automatic t_ovf;
        wr(cnt0, 32'hf0);
        rd(cnt0, 32'hf0, "preload when off");
        wr(ctl0, 32'h90);
        wr(cnt0, 32'h80);
        xfer(1'b0, cnt0, 32'h0);
        chk("preload waits", 32'(q[7:4] == 4'hf), 32'h1);
        tick(16);
        rd(sts, 32'h1, "overflow flag");
        irq_is(1'b0, "irq masked");
        xfer(1'b0, cnt0, 32'h0);
        chk("reload value", 32'(q[7:5] == 3'h4), 32'h1);
        wr(msk, 32'h1);
        irq_is(1'b1, "irq unmasked");
        wr(sts, 32'h1);
        irq_is(1'b0, "irq cleared");
        wr(ctl0, 32'h80);
    endtask
    // edge counting, prescaler set high, second unit
    task automatic t_evt;
        wr(cnt0, 32'h0);
        wr(ctl0, 32'h57);
        u_tec_pin_src.toggle(0, 5, 4);
        tick(6);
        rd(cnt0, 32'h3, "rising edges");
        wr(ctl0, 32'h5f);
        u_tec_pin_src.toggle(0, 5, 4);
        tick(6);
        rd(cnt0, 32'h6, "falling edges");
        wr(cnt1, 32'h0);
        wr(ctl1, 32'h50);
        u_tec_pin_src.toggle(1, 4, 2);
        tick(6);
        rd(cnt1, 32'h2, "unit1 edges");
        rd(cnt0, 32'h6, "unit0 untouched");
    endtask
    // overflow during power-down
    task automatic t_wake;
        power_down <= 1'b1;
        wr(ctl1, 32'h40);
        wr(cnt1, 32'hff);
        wr(ctl1, 32'h50);
        u_tec_pin_src.toggle(1, 2, 4);
        tick(6);
        chk("wake seen", woke, 32'h1);
        rd(sts, 32'h2, "unit1 flag");
        rd(cnt1, 32'hff, "reload preload");
        power_down <= 1'b0;
        wr(sts, 32'h3);
    endtask
    // pulse width for both active levels
    task automatic t_pw;
        for (int e = 1; e >= 0; e--) begin
            wr(ctl0, 32'h0);
            if (timer_pin[0] === e[0]) u_tec_pin_src.toggle(0, 1, 4);
            wr(cnt0, 32'h0);
            wr(ctl0, 32'hd0 | (e << 3));
            tick(20);
            rd(cnt0, 32'h0, "armed idle");
            u_tec_pin_src.toggle(0, 2, 40);
            xfer(1'b0, cnt0, 32'h0);
            q2 = q;
            chk("pulse width", 32'(q >= 38 && q <= 42), 32'h1);
            rd(ctl0, 32'hc0 | (e << 3), "run cleared");
            u_tec_pin_src.toggle(0, 2, 8);
            rd(cnt0, q2, "later edges");
        end
    endtask
    // clock enable low freezes a running timer
    task automatic t_ce;
        wr(cnt0, 32'h0);
        wr(ctl0, 32'h90);
        ce <= 1'b0;
        tick(30);
        ce <= 1'b1;
        wr(ctl0, 32'h80);
        xfer(1'b0, cnt0, 32'h0);
        chk("ce freeze", 32'(q <= 3), 32'h1);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs;
        t_psc;
        t_ovf;
        t_evt;
        t_wake;
        t_pw;
        t_ce;
        close_out;
    end
endmodule
`default_nettype wire
